// File: hdl/cdm_pkg.sv
// Functional notes
// RQ1 - Counting starts only at next selected tick.
// RQ2 - Delay equals count plus one ticks.
// RQ3 - Delay mode reproduces selected input edge later.
// RQ4 - Previous cell output may clock this cell.
// RQ5 - One-shot pulse width ignores input length.
// RQ6 - Polarity selects true or inverted output.
// RQ7 - Hold timer asserts after continuous input.
// RQ8 - Count value and clock source configurable.
// RQ9 - Delay mode suppresses pulses shorter than delay.
// RQ10 - Every trigger reloads counter from count.
`default_nettype none
package cdm_pkg;
	// Width of the count, divider and down-counter.
	localparam int CNT_W = 16;
	// Register byte offsets.
	localparam logic [31:0] OFS_CTRL  = 32'h0000_0000;
	localparam logic [31:0] OFS_COUNT = 32'h0000_0004;
	localparam logic [31:0] OFS_DIV   = 32'h0000_0008;
	localparam logic [31:0] OFS_STAT  = 32'h0000_000c;
	// Mode field encodings.
	localparam logic [1:0] MODE_DELAY   = 2'h0;
	localparam logic [1:0] MODE_ONESHOT = 2'h1;
	localparam logic [1:0] MODE_COUNT   = 2'h2;
	// Edge select encodings; zero selects no edge.
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	// Clock source encodings.
	localparam logic [1:0] CSEL_DIV   = 2'h0;
	localparam logic [1:0] CSEL_EXT   = 2'h1;
	localparam logic [1:0] CSEL_CHAIN = 2'h2;
	// Reset values.
	localparam logic [7:0]       CTRL_RST  = 8'h00;
	localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;
	localparam logic [CNT_W-1:0] DIV_RST   = 16'h0000;
	// Bus responses.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// Control register layout, bit 0 at the right.
	typedef struct packed {
		logic [1:0] csel;     // Clock source.
		logic       inv;      // Drive the inverted output on the pin.
		logic [1:0] edge_sel; // Triggering edge.
		logic [1:0] mode;     // Delay, one-shot or counter.
		logic       en;       // Cell enable.
	} cdm_ctrl_t;

	// Whole state of the cell.
	typedef struct packed {
		cdm_ctrl_t        ctrl;
		logic [CNT_W-1:0] count;
		logic [CNT_W-1:0] div;
		logic [CNT_W-1:0] div_cnt;
		logic [CNT_W-1:0] cnt;
		logic             trig_m;
		logic             trig_s;
		logic             trig_p;
		logic             ext_m;
		logic             ext_s;
		logic             ext_p;
		logic             chain_p;
		logic             busy;
		logic             core;
		logic             pin;
		logic             aw_ok;
		logic             w_ok;
		logic [31:0]      awaddr;
		logic [31:0]      wdata;
		logic [3:0]       wstrb;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             rvalid;
		logic [1:0]       rresp;
		logic [31:0]      rdata;
	} cdm_state_t;
endpackage
`default_nettype wire

// File: hdl/cdm_count_delay_cell.sv
`timescale 1ns/100ps
`default_nettype none
module cdm_count_delay_cell (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [31:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [31:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        trig_in,
	input  wire logic        ext_clk_in,
	input  wire logic        chain_in,
	output logic             cell_out,
	output logic             inverted_output,
	output logic             chain_out
);
	cdm_pkg::cdm_state_t s, n; // Registered state and its next value.
	logic tick;                // Active edge of the selected source.
	logic rise;                // Synchronised trigger rose.
	logic fall;                // Synchronised trigger fell.
	logic hit;                 // Trigger edge matches the edge select.

	// Merges a write word into a register under the byte strobes.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// True when the offset names a register of the cell.
	function automatic logic mapped(input logic [31:0] a);
		return a == cdm_pkg::OFS_CTRL || a == cdm_pkg::OFS_COUNT ||
			a == cdm_pkg::OFS_DIV || a == cdm_pkg::OFS_STAT;
	endfunction

	// Bus handshakes come straight from the held flags.
	assign awready = !s.aw_ok && !s.bvalid;
	assign wready  = !s.w_ok && !s.bvalid;
	assign arready = !s.rvalid;
	assign bvalid  = s.bvalid;
	assign bresp   = s.bresp;
	assign rvalid  = s.rvalid;
	assign rresp   = s.rresp;
	assign rdata   = s.rdata;
	// Pin output, its complement and the true output for a following cell.
	assign cell_out        = s.pin;
	assign inverted_output = !s.pin;
	assign chain_out       = s.core;

	// Edge detection on the synchronised trigger, after both flops.
	always_comb begin
		rise = s.trig_s && !s.trig_p;
		fall = !s.trig_s && s.trig_p;
		hit  = (s.ctrl.edge_sel[0] && rise) || (s.ctrl.edge_sel[1] && fall);
	end

	// Tick selection; the source is free-running and not aligned to the trigger.
	always_comb begin
		unique case (s.ctrl.csel)
			cdm_pkg::CSEL_DIV: begin
				tick = s.div_cnt == s.div;
			end
			cdm_pkg::CSEL_EXT: begin
				tick = s.ext_s && !s.ext_p; // [RQ8]
			end
			cdm_pkg::CSEL_CHAIN: begin
				tick = chain_in && !s.chain_p; // [RQ4]
			end
			default: begin
				tick = 1'b0;
			end
		endcase
	end

	// Next-state logic for the cell and its register slave.
	always_comb begin
		n = s;
		// Two-flop synchronisers for pin inputs; chain input is on this clock.
		n.trig_m  = trig_in;
		n.trig_s  = s.trig_m;
		n.trig_p  = s.trig_s;
		n.ext_m   = ext_clk_in;
		n.ext_s   = s.ext_m;
		n.ext_p   = s.ext_s;
		n.chain_p = chain_in;
		// Prescaler runs all the time, so an enable lands mid-period.
		n.div_cnt = (s.div_cnt == s.div) ? '0 : s.div_cnt + 16'h0001;
		if (!s.ctrl.en) begin
			// Disabled cell is idle and preloaded.
			n.busy = 1'b0;
			n.core = 1'b0;
			n.cnt  = s.count;
		end else begin
			unique case (s.ctrl.mode)
				cdm_pkg::MODE_DELAY: begin
					if (hit) begin
						// Load now, count from the next tick only.
						n.busy = 1'b1; // [RQ1]
						n.cnt  = s.count; // [RQ10]
					end else if (rise || fall) begin
						// Unselected edge passes at once and kills a short pulse.
						n.busy = 1'b0; // [RQ9]
						n.core = s.trig_s;
					end else if (s.busy && tick) begin
						if (s.cnt == '0) begin
							// Level held for count plus one ticks reaches the output.
							n.busy = 1'b0;
							n.core = s.trig_s; // [RQ2] [RQ3] [RQ7]
						end else begin
							n.cnt = s.cnt - 16'h0001;
						end
					end
				end
				cdm_pkg::MODE_ONESHOT: begin
					if (hit) begin
						// Start or restart the pulse with a full interval.
						n.busy = 1'b1;
						n.core = 1'b1; // [RQ5]
						n.cnt  = s.count; // [RQ10]
					end else if (s.busy && tick) begin
						if (s.cnt == '0) begin
							n.busy = 1'b0;
							n.core = 1'b0; // [RQ5]
						end else begin
							n.cnt = s.cnt - 16'h0001;
						end
					end
				end
				cdm_pkg::MODE_COUNT: begin
					// Free count; one tick-long high at each wrap.
					n.busy = 1'b1;
					if (tick) begin
						if (s.cnt == '0) begin
							n.cnt  = s.count;
							n.core = 1'b1; // [RQ4]
						end else begin
							n.cnt  = s.cnt - 16'h0001;
							n.core = 1'b0;
						end
					end
				end
				default: begin
					n.busy = 1'b0;
					n.core = 1'b0;
				end
			endcase
		end
		// Pin polarity follows the true output.
		n.pin = n.core ^ s.ctrl.inv; // [RQ6]
		// Address and data are taken in either order and held.
		if (awvalid && awready) begin
			n.aw_ok  = 1'b1;
			n.awaddr = awaddr;
		end
		if (wvalid && wready) begin
			n.w_ok  = 1'b1;
			n.wdata = wdata;
			n.wstrb = wstrb;
		end
		// Once both are held the write lands and the response is raised.
		if (s.aw_ok && s.w_ok) begin
			n.aw_ok  = 1'b0;
			n.w_ok   = 1'b0;
			n.bvalid = 1'b1;
			n.bresp  = mapped(s.awaddr) ? cdm_pkg::RESP_OKAY : cdm_pkg::RESP_DECERR;
			unique case (s.awaddr)
				cdm_pkg::OFS_CTRL: begin
					// Only the low byte exists; the upper lanes are dropped on purpose.
					n.ctrl = cdm_pkg::cdm_ctrl_t'(8'(merge({24'h0, s.ctrl}, s.wdata, s.wstrb)));
				end
				cdm_pkg::OFS_COUNT: begin
					n.count = 16'(merge({16'h0, s.count}, s.wdata, s.wstrb)); // [RQ8]
				end
				cdm_pkg::OFS_DIV: begin
					n.div = 16'(merge({16'h0, s.div}, s.wdata, s.wstrb));
				end
				default: begin
				end
			endcase
		end else if (s.bvalid && bready) begin
			n.bvalid = 1'b0;
		end
		// Reads answer one cycle after the address is taken.
		if (arvalid && arready) begin
			n.rvalid = 1'b1;
			n.rresp  = mapped(araddr) ? cdm_pkg::RESP_OKAY : cdm_pkg::RESP_DECERR;
			unique case (araddr)
				cdm_pkg::OFS_CTRL: n.rdata = {24'h0, s.ctrl};
				cdm_pkg::OFS_COUNT: n.rdata = {16'h0, s.count};
				cdm_pkg::OFS_DIV: n.rdata = {16'h0, s.div};
				cdm_pkg::OFS_STAT: n.rdata = {s.cnt, 13'h0, s.pin, s.busy, s.core};
				default: n.rdata = 32'h0000_0000;
			endcase
		end else if (s.rvalid && rready) begin
			n.rvalid = 1'b0;
		end
	end

	// State register with synchronous active-low reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s       <= '0;
			s.ctrl  <= cdm_pkg::CTRL_RST;
			s.count <= cdm_pkg::COUNT_RST;
			s.div   <= cdm_pkg::DIV_RST;
		end else begin
			s <= n;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic dly, one, cnt_mode; // Mode decodes for the checks.
	assign dly      = s.ctrl.en && s.ctrl.mode == cdm_pkg::MODE_DELAY;
	assign one      = s.ctrl.en && s.ctrl.mode == cdm_pkg::MODE_ONESHOT;
	assign cnt_mode = s.ctrl.en && s.ctrl.mode == cdm_pkg::MODE_COUNT;

	property p_start_load;
		dly && hit |=> s.busy && s.cnt == $past(s.count);
	endproperty
	a_start_load: assert property (p_start_load) else $error("trigger did not load count"); // [RQ1]

	property p_expire;
		dly && s.busy && tick && s.cnt == '0 && !rise && !fall |=> s.core == $past(s.trig_s) && !s.busy;
	endproperty
	a_expire: assert property (p_expire) else $error("delay did not expire on last tick"); // [RQ2]

	// With rising select only an expiring count may raise the output, and it copies the held level.
	property p_delay_rise;
		dly && s.ctrl.edge_sel == cdm_pkg::EDGE_RISE && $rose(s.core) && $stable(s.ctrl)
			|-> $past(s.busy) && $past(s.trig_s);
	endproperty
	a_delay_rise: assert property (p_delay_rise) else $error("delay output rose without hold"); // [RQ3]

	// A chained counter must hold its count between completions of the previous cell.
	property p_chain_tick;
		cnt_mode && s.ctrl.csel == cdm_pkg::CSEL_CHAIN && !(chain_in && !s.chain_p) |=> $stable(s.cnt);
	endproperty
	a_chain_tick: assert property (p_chain_tick) else $error("count moved without chain edge"); // [RQ4]

	property p_oneshot_hold;
		one && hit && s.count != '0 ##1 $stable(s.ctrl) |-> s.core ##1 s.core;
	endproperty
	a_oneshot_hold: assert property (p_oneshot_hold) else $error("one-shot pulse ended early"); // [RQ5]

	property p_polarity;
		$stable(s.ctrl.inv) |-> cell_out == (s.core ^ s.ctrl.inv);
	endproperty
	a_polarity: assert property (p_polarity) else $error("pin polarity wrong"); // [RQ6]

	property p_hold_level;
		dly && s.ctrl.edge_sel == cdm_pkg::EDGE_RISE && s.core |-> s.trig_p || $past(s.trig_s);
	endproperty
	a_hold_level: assert property (p_hold_level) else $error("hold output high with input low"); // [RQ7]

	property p_count_write;
		s.aw_ok && s.w_ok && s.awaddr == cdm_pkg::OFS_COUNT && s.wstrb == 4'hf
			|=> s.count == $past(s.wdata[15:0]);
	endproperty
	a_count_write: assert property (p_count_write) else $error("count write lost"); // [RQ8]

	property p_glitch;
		dly && s.ctrl.edge_sel == cdm_pkg::EDGE_RISE && fall |=> !s.core && !s.busy;
	endproperty
	a_glitch: assert property (p_glitch) else $error("short high pulse not suppressed"); // [RQ9]

	property p_retrigger;
		one && hit |=> s.cnt == $past(s.count) && s.core;
	endproperty
	a_retrigger: assert property (p_retrigger) else $error("retrigger did not reload"); // [RQ10]

	property p_cv_delay;
		dly && $rose(s.core);
	endproperty
	c_cv_delay: cover property (p_cv_delay);

	property p_cv_oneshot;
		one && $fell(s.core);
	endproperty
	c_cv_oneshot: cover property (p_cv_oneshot);

	property p_cv_wrap;
		s.ctrl.mode == cdm_pkg::MODE_COUNT && $rose(s.core);
	endproperty
	c_cv_wrap: cover property (p_cv_wrap);
endmodule
`default_nettype wire

// File: verification/cdm_glue_model.sv
`timescale 1ns/100ps
`default_nettype none
// Glue logic beside the cell: a slow external oscillator and the pulse of a previous cell.
module cdm_glue_model #(
	parameter int EXT_HALF = 3, // Half period of the external oscillator in aclk cycles.
	parameter int CHAIN_P  = 5  // Spacing of the previous cell's completion pulses.
) (
	input  wire logic aclk,
	output logic      ext_clk_in,
	output logic      chain_in
);
	int n = 0; // Phase counter over one common period of both sources.

	// Both outputs are unknown until the first edge, which falls inside reset.
	// The oscillator runs free and is never aligned to the cell's enable.
	always @(posedge aclk) begin
		n <= (n + 1) % (2 * EXT_HALF * CHAIN_P);
		ext_clk_in <= ((n / EXT_HALF) % 2) == 0;
		chain_in <= (n % CHAIN_P) == 0;
	end
endmodule
`default_nettype wire

// File: verification/test_counter_delay_macrocell.sv
`timescale 1ns/100ps
`default_nettype none
module test_counter_delay_macrocell;
	logic        aclk = 1'b0;    // Bus clock, 100 MHz.
	logic        aresetn = 1'b0; // Synchronous reset, active low.
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, seed = 32'h956faa85;
	logic [3:0]  wstrb = 4'hf;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, trig_in = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, ext_clk_in, chain_in;
	logic        cell_out, inverted_output, chain_out;
	logic [1:0]  bresp, rresp;
	logic [1:0]  bq[$];  // Expected write responses.
	logic [65:0] rq[$];  // Expected read response, mask and data.
	int          mismatches = 0, checked = 0, d, e, c, f;

	cdm_count_delay_cell u_cdm_count_delay_cell (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .trig_in, .ext_clk_in, .chain_in, .cell_out, .inverted_output, .chain_out);
	cdm_glue_model u_cdm_glue_model (.aclk, .ext_clk_in, .chain_in);

	always #5 aclk = ~aclk;

	// Xorshift source for the count values.
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Control word with the cell enabled.
	function automatic logic [31:0] ctl(input logic [1:0] m, g, input logic v, input logic [1:0] s);
		return {24'h0, s, v, g, m, 1'b1};
	endfunction

	task automatic chk(input string s, input logic [31:0] x, v);
		checked++;
		if (v !== x) begin
			mismatches++;
			$display("Error %s expected %h seen %h", s, x, v);
		end
	endtask

	task automatic end_of_test();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// A bus wait that ran out ends the run.
	task automatic tmo(input int n);
		if (n == 40) begin
			mismatches++;
			end_of_test();
		end
	endtask

	// One write; the response handshake closes it.
	task automatic axw(input logic [31:0] a, dt, input logic [1:0] r);
		int n;
		logic [2:0] hs;
		begin
			bq.push_back(r);
			@(posedge aclk);
			awaddr <= a;
			wdata <= dt;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			for (n = 0; n < 40; n++) begin
				@(negedge aclk);
				hs = {awvalid & awready, wvalid & wready, bvalid};
				@(posedge aclk);
				if (hs[2]) awvalid <= 1'b0;
				if (hs[1]) wvalid <= 1'b0;
				if (hs[0]) break;
			end
			bready <= 1'b0;
			tmo(n);
		end
	endtask

	// One read; expected data under a mask.
	task automatic axr(input logic [31:0] a, x, m, input logic [1:0] r);
		int n;
		logic [1:0] hs;
		begin
			rq.push_back({r, m, x});
			@(posedge aclk);
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			for (n = 0; n < 40; n++) begin
				@(negedge aclk);
				hs = {arvalid & arready, rvalid};
				@(posedge aclk);
				if (hs[1]) arvalid <= 1'b0;
				if (hs[0]) break;
			end
			rready <= 1'b0;
			tmo(n);
		end
	endtask

	// Counts cycles until the chained output shows a level; running out ends the run.
	task automatic wt(input logic lv, input int lim, output int n);
		for (n = 0; n < lim && chain_out !== lv; n++) @(negedge aclk);
		if (chain_out !== lv) begin
			mismatches++;
			$display("Error wait expected %h seen %h", lv, chain_out);
			end_of_test();
		end
	endtask

	// Checks that the chained output keeps a level for a number of cycles.
	task automatic keep(input string s, input logic lv, input int lim);
		int n;
		for (n = 0; n < lim && chain_out === lv; n++) @(negedge aclk);
		chk(s, 32'(lim), 32'(n));
	endtask

	// Watcher: each response seen is matched with the oldest note.
	always @(negedge aclk) begin
		if (bvalid && bready) chk("bresp", 32'(bq.pop_front()), 32'(bresp));
		if (rvalid && rready) begin
			chk("rresp", 32'(rq[0][65:64]), 32'(rresp));
			chk("rdata", rq[0][31:0], rdata & rq[0][63:32]);
			void'(rq.pop_front());
		end
	end

	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 5; i++) axr(32'(i * 4), 0, '1, (i == 4) ? 2'h3 : 2'h0);
		axw(cdm_pkg::OFS_STAT, '1, cdm_pkg::RESP_OKAY);
		axw(32'h10, 0, cdm_pkg::RESP_DECERR);
		axr(cdm_pkg::OFS_STAT, 0, '1, cdm_pkg::RESP_OKAY);
		$display("registers done");
		// Delay mode: a short pulse is swallowed, a held level comes through late.
		c = 4 + int'(rnd() % 8);
		axw(cdm_pkg::OFS_COUNT, c, cdm_pkg::RESP_OKAY);
		axr(cdm_pkg::OFS_COUNT, c, 32'hffff, cdm_pkg::RESP_OKAY);
		axw(cdm_pkg::OFS_CTRL, ctl(cdm_pkg::MODE_DELAY, cdm_pkg::EDGE_RISE, 0, 0), 0);
		trig_in <= 1'b1;
		repeat (2) @(posedge aclk);
		trig_in <= 1'b0;
		keep("filter", 1'b0, c + 12);
		@(posedge aclk);
		trig_in <= 1'b1;
		wt(1'b1, 40, d);
		// Divider is zero, so a tick each cycle: three cycles of input path, count plus one ticks, one register.
		chk("delay", 1, 32'(d >= c + 5 && d <= c + 6));
		chk("pin", 32'(chain_out), 32'(cell_out));
		@(posedge aclk);
		trig_in <= 1'b0;
		$display("delay done");
		// One-shot on the inverted pin while the input stays high.
		axw(cdm_pkg::OFS_CTRL, ctl(cdm_pkg::MODE_ONESHOT, cdm_pkg::EDGE_RISE, 1, 0), 0);
		trig_in <= 1'b1;
		wt(1'b1, 40, d);
		wt(1'b0, 40, d);
		chk("width", 1, 32'(d >= c + 1 && d <= c + 3));
		chk("inv", 32'(!chain_out), 32'(cell_out));
		chk("inverted_output", 32'(!cell_out), 32'(inverted_output));
		@(posedge aclk);
		trig_in <= 1'b0;
		$display("oneshot done");
		// Falling select: a rise passes at once, a short low is swallowed, a held low comes late.
		axw(cdm_pkg::OFS_CTRL, ctl(cdm_pkg::MODE_DELAY, cdm_pkg::EDGE_FALL, 0, 0), 0);
		trig_in <= 1'b1;
		wt(1'b1, 40, d);
		chk("pass", 1, 32'(d <= 5));
		@(posedge aclk);
		trig_in <= 1'b0;
		repeat (2) @(posedge aclk);
		trig_in <= 1'b1;
		keep("low filter", 1'b1, c + 12);
		@(posedge aclk);
		trig_in <= 1'b0;
		wt(1'b0, 40, d);
		chk("fall delay", 1, 32'(d >= c + 5 && d <= c + 6));
		$display("fall done");
		// Counter mode over every clock source; the period is exact.
		axw(cdm_pkg::OFS_DIV, 32'h3, 0);
		for (int i = 0; i < 3; i++) begin
			f = (i == 0) ? 4 : (i == 1) ? 6 : 5;
			axw(cdm_pkg::OFS_CTRL, ctl(cdm_pkg::MODE_COUNT, 0, 0, 2'(i)), 0);
			wt(1'b0, 200, d);
			wt(1'b1, 200, d);
			wt(1'b0, 200, d);
			wt(1'b1, 200, e);
			chk("period", (c + 1) * f, d + e);
		end
		$display("counter done");
		end_of_test();
	end
endmodule
`default_nettype wire
